// ---- rtl/tcp_consts.svh ----
// constants for the timer/counter with prescaler
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH
// instruction cycle = four phase clocks
`define TCP_CLK_NS 50
`define TCP_PHASES_PER_CYC 4
`define TCP_CYC_W 2
// writes hold off counting for this many instruction cycles
`define TCP_WR_HOLD 2
`define TCP_HOLD_W 2
`define TCP_PRE_W 8
`define TCP_PS_W 3
`define TCP_CNT_RST 16'h0000
`define TCP_PRE_RST 8'h00
`define TCP_LOW_MAX 8'hff
`define TCP_FULL_MAX 16'hffff
`endif

// ---- rtl/tcp_pkg.sv ----
// types for the timer/counter with prescaler
package tcp_pkg;
  typedef enum logic [1:0] {
    TCP_SRC_TIMER = 2'b01,
    TCP_SRC_COUNTER = 2'b10
  } tcp_src_t;
endpackage

// ---- rtl/tcp_edge_sync.sv ----
// synchroniser and edge detector for the external count input
`timescale 1ns/1ns
`default_nettype none
module tcp_edge_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pin,
  input wire logic falling,
  output logic edge_pulse
);
  logic s1, s2, s3;
  logic next_s1, next_s2, next_s3;

  // ---------------------------------------------------------------
  // two-flop synchroniser, third flop for edge history
  // ---------------------------------------------------------------
  always_comb begin
    next_s1 = pin;
    next_s2 = s1;
    next_s3 = s2;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
    end
  end

  // s1 is never looked at here: metastability stays in the chain
  assign edge_pulse = falling ? (s3 & ~s2) : (~s3 & s2);
endmodule
`default_nettype wire

// ---- rtl/tcp_timer.sv ----
// timer/counter with 8-bit prescaler and overflow flag
`timescale 1ns/1ns
`default_nettype none
`include "tcp_consts.svh"
module tcp_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire tcp_pkg::tcp_src_t clock_source_select,
  input wire logic source_edge_select,
  input wire logic prescaler_assign,
  input wire logic [2:0] prescale_select,
  input wire logic timer_on,
  input wire logic eight_bit_mode,
  input wire logic overflow_irq_enable,
  input wire logic external_count_input,
  input wire logic low_write,
  input wire logic low_read,
  input wire logic high_write,
  input wire logic [7:0] wdata,
  input wire logic flag_clear,
  input wire logic sleeping,
  output logic [7:0] low_count_byte,
  output logic [7:0] high_byte_buffer,
  output logic overflow_flag,
  output logic irq,
  output logic wake
);
  import tcp_pkg::*;

  logic [15:0] count, next_count;
  logic [7:0] hbuf, next_hbuf;
  logic [7:0] pre, next_pre;
  logic [`TCP_CYC_W-1:0] phase, next_phase;
  logic [`TCP_HOLD_W-1:0] hold, next_hold;
  logic flag, next_flag;
  logic cyc_tick, ext_edge, src_ev, pre_out, inc, wrap;
  logic [7:0] pre_mask;

  // ---------------------------------------------------------------
  // count sources
  // ---------------------------------------------------------------
  tcp_edge_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin(external_count_input),
    .falling(source_edge_select),
    .edge_pulse(ext_edge)
  );

  assign cyc_tick = (phase == 2'(`TCP_PHASES_PER_CYC - 1));
  // timer mode ticks per cycle, counter mode per edge
  assign src_ev = timer_on &&
    ((clock_source_select == TCP_SRC_TIMER) ? cyc_tick :
     (clock_source_select == TCP_SRC_COUNTER) && ext_edge);

  // prescaler output fires when all low n+1 bits are ones
  assign pre_mask = 8'((9'h002 << prescale_select) - 9'h001);
  assign pre_out = ((pre & pre_mask) == pre_mask);
  // assignment read live each event, so it may change any time
  assign inc = src_ev && (hold == 2'h0) &&
    (prescaler_assign ? 1'b1 : pre_out);
  assign wrap = inc && (eight_bit_mode ?
    (count[7:0] == `TCP_LOW_MAX) : (count == `TCP_FULL_MAX));

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_phase = phase + 2'h1;
    next_pre = pre;
    next_count = count;
    next_hbuf = hbuf;
    next_hold = hold;
    next_flag = flag;
    if (hold != 2'h0 && cyc_tick) begin
      next_hold = hold - 2'h1;
    end
    if (src_ev && !prescaler_assign) begin
      next_pre = pre + 8'h01; // internal only, no port reads it
    end
    if (inc) begin
      next_count = count + 16'h0001;
      if (eight_bit_mode) begin
        next_count[15:8] = count[15:8];
      end
    end
    if (high_write) begin
      next_hbuf = wdata;
    end
    if (low_read && !eight_bit_mode) begin
      next_hbuf = count[15:8];
    end
    if (low_write) begin
      next_count[7:0] = wdata;
      if (!eight_bit_mode) begin
        next_count[15:8] = hbuf; // all sixteen bits at once
      end
      next_hold = 2'(`TCP_WR_HOLD);
      if (!prescaler_assign) begin
        next_pre = `TCP_PRE_RST; // assignment bit untouched
      end
    end
    // set wins over a clear in the same cycle
    if (flag_clear) begin
      next_flag = 1'b0; // only software clears
    end
    if (wrap) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase <= 2'h0;
      pre <= `TCP_PRE_RST;
      count <= `TCP_CNT_RST;
      hbuf <= 8'h00;
      hold <= 2'h0;
      flag <= 1'b0;
    end else begin
      phase <= next_phase;
      pre <= next_pre;
      count <= next_count;
      hbuf <= next_hbuf;
      hold <= next_hold;
      flag <= next_flag;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign low_count_byte = count[7:0];
  assign high_byte_buffer = hbuf;
  assign overflow_flag = flag;
  assign irq = flag && overflow_irq_enable;
  // clocks stop in sleep, so this source can never wake the core;
  // the sleeping input is kept for the core's sake and read nowhere here
  assign wake = 1'b0;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_low_write;
    low_write;
  endsequence

  a_irq_mask: assert property (@(posedge mclk) disable iff (rst)
    irq == (overflow_flag && overflow_irq_enable))
    else $error("irq not gated by enable");
  a_flag_sticky: assert property (@(posedge mclk) disable iff (rst)
    $fell(overflow_flag) |-> $past(flag_clear))
    else $error("flag cleared without software");
  a_wrap_sets: assert property (@(posedge mclk) disable iff (rst)
    wrap |=> overflow_flag)
    else $error("wrap did not set flag");
  // an edge can restart the count right after the second tick, so up to six quiet cycles are safe
  a_write_hold: assert property (@(posedge mclk) disable iff (rst)
    s_low_write ##1 !low_write[*5] |-> $stable(count))
    else $error("count moved during hold");
  a_pre_clear: assert property (@(posedge mclk) disable iff (rst)
    low_write && !prescaler_assign |=> pre == 8'h00)
    else $error("prescaler not cleared");
  a_low_load: assert property (@(posedge mclk) disable iff (rst)
    low_write && !eight_bit_mode |=>
      count == {$past(hbuf), $past(wdata)})
    else $error("sixteen-bit load wrong");
  a_read_latch: assert property (@(posedge mclk) disable iff (rst)
    low_read && !eight_bit_mode && !high_write |=>
      hbuf == $past(count[15:8]))
    else $error("high byte not latched");
  a_no_wake: assert property (@(posedge mclk) disable iff (rst)
    !wake)
    else $error("wake asserted");
  a_timer_step: assert property (@(posedge mclk) disable iff (rst)
    inc && prescaler_assign && !low_write && eight_bit_mode |=>
      count[7:0] == 8'($past(count[7:0]) + 8'h01))
    else $error("timer did not step");

  // a wrap racing a software clear must leave the flag set
  sequence s_wrap_clear;
    wrap && flag_clear;
  endsequence

  a_set_wins: assert property (@(posedge mclk) disable iff (rst)
    s_wrap_clear |=> overflow_flag)
    else $error("clear beat a wrap");
  a_hold_load: assert property (@(posedge mclk) disable iff (rst)
    s_low_write |=> hold == 2'(`TCP_WR_HOLD))
    else $error("hold not loaded");
  a_eight_keep: assert property (@(posedge mclk) disable iff (rst)
    inc && eight_bit_mode && !low_write |=>
      count[15:8] == $past(count[15:8]))
    else $error("high byte moved in eight-bit mode");
  a_pre_gate: assert property (@(posedge mclk) disable iff (rst)
    inc && !prescaler_assign |-> pre_out)
    else $error("step without prescaler output");
  a_bypass_step: assert property (@(posedge mclk) disable iff (rst)
    src_ev && prescaler_assign && hold == 2'h0 && !low_write |=>
      count != $past(count))
    else $error("bypassed event did not step");
  a_ext_gate: assert property (@(posedge mclk) disable iff (rst)
    clock_source_select == TCP_SRC_COUNTER && !ext_edge |-> !src_ev)
    else $error("counter stepped without an edge");
  a_off_still: assert property (@(posedge mclk) disable iff (rst)
    !timer_on |-> !inc)
    else $error("counted while off");
endmodule
`default_nettype wire

// ---- tb/tcp_pulse_src.sv ----
// pulse source model driving the external count input
`timescale 1ns/1ns
`default_nettype none
module tcp_pulse_src (
  input wire logic mclk,
  input wire logic lvl,
  output logic pin
);
  logic [1:0] dly = 2'b00;
  // lags the request and moves off the clock edge; each level is held
  // for many cycles, enough for the synchroniser to catch it
  always @(posedge mclk) begin
    dly <= #7 {dly[0], lvl};
  end
  assign pin = dly[1];
endmodule
`default_nettype wire

// ---- tb/tcp_timer_bench.sv ----
// self-checking bench for the timer/counter with prescaler
`timescale 1ns/1ns
`default_nettype none
module tcp_timer_bench;
  import tcp_pkg::*;
  tcp_src_t clock_source_select = TCP_SRC_TIMER;
  logic mclk = 0, rst = 1, source_edge_select = 0, prescaler_assign = 1;
  logic timer_on = 0, eight_bit_mode = 1, overflow_irq_enable = 1, lvl = 0;
  logic low_write = 0, low_read = 0, high_write = 0, flag_clear = 0;
  logic sleeping = 0, ext_pin, overflow_flag, irq, wake;
  logic [2:0] prescale_select = 3'h0;
  logic [7:0] wdata = 8'h00, v, low_count_byte, high_byte_buffer;
  int errors = 0, n_compared = 0, i;
  // ----------------------------------------
  // clock, design and source model
  // ----------------------------------------
  initial forever #25 mclk = ~mclk;
  tcp_timer uut (.mclk, .rst, .clock_source_select, .source_edge_select,
    .prescaler_assign, .prescale_select, .timer_on, .eight_bit_mode,
    .overflow_irq_enable, .external_count_input(ext_pin), .low_write,
    .low_read, .high_write, .wdata, .flag_clear, .sleeping,
    .low_count_byte, .high_byte_buffer, .overflow_flag, .irq, .wake);
  tcp_pulse_src src_model (.mclk(mclk), .lvl(lvl), .pin(ext_pin));
  // ----------------------------------------
  // access and check tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // let edge updates land before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // k: 1 low write, 2 buffer write, 4 low read, 8 flag clear
  task automatic req(input logic [3:0] k, input logic [7:0] d);
    @(posedge mclk);
    {flag_clear, low_read, high_write, low_write} <= k;
    wdata <= d;
    @(posedge mclk);
    {flag_clear, low_read, high_write, low_write} <= 4'h0;
  endtask
  // span is whole periods, so the start phase cannot skew the count
  task automatic rate(input int span, input logic [7:0] dlt);
    v = low_count_byte;
    cyc(span);
    chk(low_count_byte, v + dlt);
  endtask
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    cyc(1);
    chk(high_byte_buffer, 8'h00);
    @(posedge mclk);
    timer_on <= 1'b1;
    req(4'h1, 8'h10);
    cyc(3);
    chk(low_count_byte, 8'h10);
    cyc(9);
    rate(40, 8'h0a);
    $display("test timer mode done");
    @(posedge mclk);
    prescaler_assign <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge mclk);
      prescale_select <= i[2:0];
      req(4'h1, 8'h00);
      cyc(12);
      rate(16 << i, 8'h02);
    end
    @(posedge mclk);
    prescaler_assign <= 1'b1;
    cyc(2);
    rate(40, 8'h0a);
    $display("test prescaler done");
    @(posedge mclk);
    clock_source_select <= TCP_SRC_COUNTER;
    for (i = 0; i < 2; i++) begin
      @(posedge mclk);
      source_edge_select <= i[0];
      req(4'h1, 8'h00);
      cyc(12);
      @(posedge mclk);
      lvl <= 1'b1;
      cyc(12);
      chk(low_count_byte, {7'h00, ~i[0]});
      @(posedge mclk);
      lvl <= 1'b0;
      cyc(12);
      chk(low_count_byte, 8'h01);
    end
    $display("test counter mode done");
    @(posedge mclk);
    clock_source_select <= TCP_SRC_TIMER;
    sleeping <= 1'b1;
    req(4'h1, 8'hff);
    cyc(12);
    chk({overflow_flag, irq, wake}, 8'h06);
    @(posedge mclk);
    overflow_irq_enable <= 1'b0;
    cyc(20);
    chk({overflow_flag, irq}, 8'h02);
    req(4'h8, 8'h00);
    cyc(1);
    chk({overflow_flag, irq}, 8'h00);
    $display("test overflow done");
    @(posedge mclk);
    eight_bit_mode <= 1'b0;
    timer_on <= 1'b0;
    req(4'h2, 8'h12);
    req(4'h1, 8'h34);
    req(4'h2, 8'h00);
    req(4'h4, 8'h00);
    cyc(1);
    chk(high_byte_buffer, 8'h12);
    chk(low_count_byte, 8'h34);
    req(4'h2, 8'hff);
    req(4'h1, 8'hff);
    @(posedge mclk);
    timer_on <= 1'b1;
    cyc(12);
    req(4'h4, 8'h00);
    cyc(1);
    chk(high_byte_buffer, 8'h00);
    chk(overflow_flag, 8'h01);
    $display("test sixteen bit done");
    summarize;
  end
  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    summarize;
  end
endmodule
`default_nettype wire
